// ==== hw/tcb_map.svh ====
// Purpose: Offsets, reset values, header limits and codes of the transceiver control bank
// Assumes: Register offsets are byte addresses on the control port
// Notes:   Definitions only
`ifndef TCB_MAP_SVH
`define TCB_MAP_SVH

// ==========================================================
// Register offsets
`define TCB_OFF_INDEX_SEL      12'h024
`define TCB_OFF_CH_PLL_PD      12'h300
`define TCB_OFF_TX_PLL_SEL     12'h304
`define TCB_OFF_RX_PLL_SEL     12'h308
`define TCB_OFF_TX_POSTCURSOR  12'h30C
`define TCB_OFF_TX_PRECURSOR   12'h310
`define TCB_OFF_LOOPBACK       12'h314
`define TCB_OFF_TX_SYS_RESET   12'h318
`define TCB_OFF_RX_SYS_RESET   12'h31C
`define TCB_OFF_TX_POWER       12'h320
`define TCB_OFF_TX_SWING       12'h324
`define TCB_OFF_TX_INHIBIT     12'h328
`define TCB_OFF_TX_INVERT      12'h32C
`define TCB_OFF_RX_INVERT      12'h330
`define TCB_OFF_RX_EQ_SEL      12'h334
`define TCB_OFF_RX_EQ_RESET    12'h338
`define TCB_OFF_HDR_LIMIT      12'h33C
`define TCB_OFF_TX_OUT_DIV     12'h340
`define TCB_OFF_RX_OUT_DIV     12'h344
`define TCB_OFF_CHANNEL_PLL_FB_CODE   12'h348
`define TCB_OFF_CHANNEL_PLL_REF_CODE  12'h34C
`define TCB_OFF_CHANNEL_PLL_DECODED   12'h350
`define TCB_OFF_TX_LINE_RATE   12'h354
`define TCB_OFF_LOCK_STATUS    12'h358

// ==========================================================
// Reset values and header limit window
`define TCB_RST_SWING          4'hC
`define TCB_RST_EQ_SEL         1'h1
`define TCB_RST_HDR_LIMIT      4'h8
`define TCB_HDR_LIMIT_MAX      4'h8
`define TCB_HDR_LIMIT_MIN      4'h1

// ==========================================================
// PLL source codes
`define TCB_PLL_CHANNEL        2'h0
`define TCB_PLL_COMMON_ONE     2'h2
`define TCB_PLL_COMMON_ZERO    2'h3

// ==========================================================
// Divider encodings
`define TCB_OUT_DIV_MAX_CODE   3'h5
`define TCB_FB_OFFSET          8'h02
`define TCB_REF_DIV1_CODE      5'h10
`define TCB_REF_DIV1_VALUE     3'h1
`define TCB_REF_BASE_VALUE     3'h2

`endif

// ==== hw/tcb_pkg.sv ====
// Purpose: Types shared by the transceiver control bank
// Assumes: Constants come from tcb_map.svh
// Notes:   Per-channel controls travel as one packed struct
package tcb_pkg;

  // ==========================================================
  // Per-channel control image
  typedef struct packed {
    logic       channel_pll_powerdown; // Channel PLL power down
    logic [4:0] tx_postcursor;         // Post-cursor / swing trim
    logic [4:0] tx_precursor;          // Pre-emphasis
    logic [2:0] loopback_select;       // Loopback mode
    logic [1:0] tx_power_state;        // Transmit power state
    logic [3:0] tx_drive_swing;        // Driver swing
    logic       tx_output_inhibit;     // Force idle line
    logic       tx_invert;             // Transmit polarity
    logic       rx_invert;             // Receive polarity
    logic       rx_equalizer_select;   // 1 low power, 0 decision feedback
    logic       rx_equalizer_reset;    // Equalizer datapath reset
    logic [3:0] invalid_header_limit;  // Invalid headers before losing sync
    logic [2:0] tx_output_divider;     // Encoded transmit divider
    logic [2:0] rx_output_divider;     // Encoded receive divider
  } tcb_chan_type;

  // Access sequencer states
  typedef enum logic [1:0] {
    TCB_IDLE,
    TCB_SYNC,
    TCB_DONE
  } tcb_state_type;

endpackage : tcb_pkg

// ==== hw/tcb_bank.sv ====
// Purpose: Per-transceiver control bank with PLL, reset, drive and receive controls
// Assumes: Single clock; register port is a held request answered by a one-cycle ack
// Notes:   Channel-domain accesses wait a programmable settle time before ack
`timescale 1ns/1ns
`include "tcb_map.svh"

// Operation
// - Two-bit transmit PLL source, reset zero
// - Two-bit receive PLL source, same encoding
// - PLL source registers single, index ignored
// - Five-bit post-cursor passed to selected channel
// - Five-bit pre-cursor drives selected channel
// - Three-bit loopback mode, reset normal
// - Transmit system reset hits datapath and PLL
// - Receive system reset hits datapath and PLL
// - Two-bit transmit power state, reset zero
// - Driver swing resets to binary 1100
// - Inhibit forces positive low, negative high
// - Transmit invert swaps output sense
// - Receive invert flips incoming data
// - Equalizer select resets to low-power mode
// - Invalid header limit eight, drop sync
// - Rate switching needs dynamic rate build option
// - Output divider codes and word positions
// - Feedback and reference divider encodings
module tcb_bank
  import tcb_pkg::*;
#(
  parameter int NUM_CH       = 4,   // Transceiver channels
  parameter int SYNC_CYCLES  = 3,   // Settle cycles for channel-domain accesses
  parameter bit DYNAMIC_RATE = 1'b1 // Built with line rate switching
) (
  input  wire logic                     sys_clk,
  input  wire logic                     resetn,
  // Register port
  input  wire logic [11:0]              reg_addr,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  input  wire logic [31:0]              reg_wdata,
  output logic      [31:0]              reg_rdata,
  output logic                          reg_ack,
  output logic                          reg_err,
  // Channel controls
  output tcb_chan_type [NUM_CH-1:0]     chan_ctrl,
  output logic      [NUM_CH-1:0]        tx_datapath_reset,
  output logic      [NUM_CH-1:0]        rx_datapath_reset,
  output logic      [NUM_CH-1:0]        channel_pll_reset,
  output logic                          common_pll_zero_reset,
  output logic                          common_pll_one_reset,
  output logic      [1:0]               tx_pll_source_select,
  output logic      [1:0]               rx_pll_source_select,
  // Serial line image
  input  wire logic [NUM_CH-1:0]        tx_serial_bit,
  output logic      [NUM_CH-1:0]        serial_out_pos,
  output logic      [NUM_CH-1:0]        serial_out_neg,
  input  wire logic [NUM_CH-1:0]        rx_serial_bit,
  output logic      [NUM_CH-1:0]        rx_serial_data,
  // Block sync
  input  wire logic [NUM_CH-1:0]        rx_header_valid,
  input  wire logic [NUM_CH-1:0]        rx_header_invalid,
  output logic      [NUM_CH-1:0]        rx_block_lock,
  // Line rate estimate
  input  wire logic [31:0]              pll_rate_khz
);

  localparam int IW = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;
  localparam int CW = $clog2(SYNC_CYCLES + 1);

  // ==========================================================
  // Helper functions

  // Output divider code to right-shift amount; codes above max read as max
  function automatic logic [2:0] div_shift(input logic [2:0] code);
    div_shift = (code > `TCB_OUT_DIV_MAX_CODE) ? `TCB_OUT_DIV_MAX_CODE : code;
  endfunction : div_shift

  // Reference divider code to divide value
  function automatic logic [2:0] ref_value(input logic [4:0] code);
    if (code == `TCB_REF_DIV1_CODE) begin
      ref_value = `TCB_REF_DIV1_VALUE;
    end else begin
      ref_value = code[2:0] + `TCB_REF_BASE_VALUE;
    end
  endfunction : ref_value

  // Replace a header limit outside the legal window with the maximum
  function automatic logic [3:0] limit_legal(input logic [3:0] v);
    limit_legal = (v < `TCB_HDR_LIMIT_MIN || v > `TCB_HDR_LIMIT_MAX) ? `TCB_HDR_LIMIT_MAX : v;
  endfunction : limit_legal

  // ==========================================================
  // Storage and combinational decode
  tcb_state_type       state;           // Access sequencer
  logic [CW-1:0]       sync_cnt;        // Settle counter
  logic [11:0]         req_addr;        // Captured address
  logic [31:0]         req_wdata;       // Captured write data
  logic                req_write;       // Captured direction
  logic [IW-1:0]       index_sel;       // Selected channel
  logic                tx_system_reset; // Single shared transmit reset
  logic                rx_system_reset; // Single shared receive reset
  logic [7:0]          channel_pll_fb_code;    // Channel PLL feedback code
  logic [4:0]          channel_pll_ref_code;   // Channel PLL reference code
  tcb_chan_type        bank [NUM_CH];   // Per-channel images
  logic [3:0]          bad_cnt [NUM_CH];// Invalid header counters
  logic                commit;          // Write lands this cycle
  logic                mapped;          // Address decodes
  logic                chan_domain;     // Access needs settling
  logic [31:0]         next_rdata;      // Read mux
  logic [31:0]         tx_line_rate;    // Rate of selected channel
  tcb_chan_type        cur;             // Selected channel image

  assign cur = bank[index_sel];

  // Channel-domain registers are all except index, PLL codes and decode, line rate and status
  assign chan_domain = (req_addr >= `TCB_OFF_CH_PLL_PD) && (req_addr <= `TCB_OFF_RX_OUT_DIV);

  // ==========================================================
  // Access sequencer: one request at a time, settled before ack
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state     <= TCB_IDLE;
      sync_cnt  <= '0;
      req_addr  <= '0;
      req_wdata <= '0;
      req_write <= 1'b0;
    end else begin
      case (state)
        TCB_IDLE: begin
          // Write wins when both strobes arrive together
          if (reg_wr || reg_rd) begin
            req_addr  <= reg_addr;
            req_wdata <= reg_wdata;
            req_write <= reg_wr;
            sync_cnt  <= '0;
            state     <= TCB_SYNC;
          end
        end
        TCB_SYNC: begin
          // Hold the handshake until the channel side has the value
          if (!chan_domain || sync_cnt == CW'(SYNC_CYCLES)) begin
            state <= TCB_DONE;
          end else begin
            sync_cnt <= sync_cnt + 1'b1;
          end
        end
        TCB_DONE: begin
          state <= TCB_IDLE;
        end
        default: begin
          state <= TCB_IDLE;
        end
      endcase
    end
  end

  // Writes commit on the cycle the sequencer enters done
  assign commit = (state == TCB_SYNC) && req_write &&
                  (!chan_domain || sync_cnt == CW'(SYNC_CYCLES));

  // ==========================================================
  // Shared registers: index select, single PLL selects, system resets and channel PLL codes
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      index_sel            <= '0;
      tx_pll_source_select <= `TCB_PLL_CHANNEL;
      rx_pll_source_select <= `TCB_PLL_CHANNEL;
      tx_system_reset      <= 1'b0;
      rx_system_reset      <= 1'b0;
      channel_pll_fb_code         <= '0;
      channel_pll_ref_code        <= '0;
    end else if (commit) begin
      case (req_addr)
        `TCB_OFF_INDEX_SEL: begin
          // Out of range indices are ignored so the bank never aliases
          if (req_wdata < 32'(NUM_CH)) begin
            index_sel <= req_wdata[IW-1:0];
          end
        end
        `TCB_OFF_TX_PLL_SEL:   tx_pll_source_select <= req_wdata[1:0];
        `TCB_OFF_RX_PLL_SEL:   rx_pll_source_select <= req_wdata[1:0];
        `TCB_OFF_TX_SYS_RESET: tx_system_reset      <= req_wdata[0];
        `TCB_OFF_RX_SYS_RESET: rx_system_reset      <= req_wdata[0];
        `TCB_OFF_CHANNEL_PLL_FB_CODE: begin
          if (DYNAMIC_RATE) begin
            channel_pll_fb_code <= req_wdata[7:0];
          end
        end
        `TCB_OFF_CHANNEL_PLL_REF_CODE: begin
          if (DYNAMIC_RATE) begin
            channel_pll_ref_code <= req_wdata[4:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // Per-channel registers, written only at the selected index
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NUM_CH; i++) begin
        bank[i]                      <= '0;
        bank[i].tx_drive_swing       <= `TCB_RST_SWING;
        bank[i].rx_equalizer_select  <= `TCB_RST_EQ_SEL;
        bank[i].invalid_header_limit <= `TCB_RST_HDR_LIMIT;
      end
    end else if (commit) begin
      case (req_addr)
        `TCB_OFF_CH_PLL_PD:     bank[index_sel].channel_pll_powerdown <= req_wdata[0];
        `TCB_OFF_TX_POSTCURSOR: bank[index_sel].tx_postcursor       <= req_wdata[4:0];
        `TCB_OFF_TX_PRECURSOR:  bank[index_sel].tx_precursor        <= req_wdata[4:0];
        `TCB_OFF_LOOPBACK:      bank[index_sel].loopback_select     <= req_wdata[2:0];
        `TCB_OFF_TX_POWER:      bank[index_sel].tx_power_state      <= req_wdata[1:0];
        `TCB_OFF_TX_SWING:      bank[index_sel].tx_drive_swing      <= req_wdata[3:0];
        `TCB_OFF_TX_INHIBIT:    bank[index_sel].tx_output_inhibit   <= req_wdata[0];
        `TCB_OFF_TX_INVERT:     bank[index_sel].tx_invert           <= req_wdata[0];
        `TCB_OFF_RX_INVERT:     bank[index_sel].rx_invert           <= req_wdata[0];
        `TCB_OFF_RX_EQ_SEL:     bank[index_sel].rx_equalizer_select <= req_wdata[0];
        `TCB_OFF_RX_EQ_RESET:   bank[index_sel].rx_equalizer_reset  <= req_wdata[0];
        `TCB_OFF_HDR_LIMIT:     bank[index_sel].invalid_header_limit <= req_wdata[3:0];
        `TCB_OFF_TX_OUT_DIV: begin
          if (DYNAMIC_RATE) begin
            bank[index_sel].tx_output_divider <= req_wdata[2:0];
          end
        end
        `TCB_OFF_RX_OUT_DIV: begin
          if (DYNAMIC_RATE) begin
            bank[index_sel].rx_output_divider <= req_wdata[2:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // Control fan-out and reset routing
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      chan_ctrl[i]         = bank[i];
      tx_datapath_reset[i] = tx_system_reset;
      rx_datapath_reset[i] = rx_system_reset;
      // Channel PLL follows whichever direction selected it
      channel_pll_reset[i] =
        (tx_system_reset && tx_pll_source_select == `TCB_PLL_CHANNEL) ||
        (rx_system_reset && rx_pll_source_select == `TCB_PLL_CHANNEL);
    end
    common_pll_zero_reset =
      (tx_system_reset && tx_pll_source_select == `TCB_PLL_COMMON_ZERO) ||
      (rx_system_reset && rx_pll_source_select == `TCB_PLL_COMMON_ZERO);
    common_pll_one_reset =
      (tx_system_reset && tx_pll_source_select == `TCB_PLL_COMMON_ONE) ||
      (rx_system_reset && rx_pll_source_select == `TCB_PLL_COMMON_ONE);
  end

  // ==========================================================
  // Serial line image, registered per channel
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      serial_out_pos <= '0;
      serial_out_neg <= '1;
      rx_serial_data <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (bank[i].tx_output_inhibit) begin
          serial_out_pos[i] <= 1'b0;
          serial_out_neg[i] <= 1'b1;
        end else begin
          serial_out_pos[i] <= tx_serial_bit[i] ^ bank[i].tx_invert;
          serial_out_neg[i] <= ~(tx_serial_bit[i] ^ bank[i].tx_invert);
        end
        rx_serial_data[i] <= rx_serial_bit[i] ^ bank[i].rx_invert;
      end
    end
  end

  // ==========================================================
  // Block sync: count invalid headers, drop lock at the limit
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rx_block_lock <= '0;
      for (int i = 0; i < NUM_CH; i++) begin
        bad_cnt[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (rx_datapath_reset[i] || bank[i].rx_equalizer_reset) begin
          // Reset of the receive side restarts sync search
          bad_cnt[i]       <= '0;
          rx_block_lock[i] <= 1'b0;
        end else if (rx_header_invalid[i]) begin
          if (bad_cnt[i] + 1'b1 >= limit_legal(bank[i].invalid_header_limit)) begin
            bad_cnt[i]       <= '0;
            rx_block_lock[i] <= 1'b0;
          end else begin
            bad_cnt[i] <= bad_cnt[i] + 1'b1;
          end
        end else if (rx_header_valid[i]) begin
          bad_cnt[i]       <= '0;
          rx_block_lock[i] <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Line rate of the selected channel: PLL rate times two over divider
  assign tx_line_rate = (pll_rate_khz << 1) >> div_shift(cur.tx_output_divider);

  // ==========================================================
  // Read mux; unmapped addresses read zero and flag an error
  always_comb begin
    next_rdata = '0;
    mapped     = 1'b1;
    case (req_addr)
      `TCB_OFF_INDEX_SEL:     next_rdata = 32'(index_sel);
      `TCB_OFF_CH_PLL_PD:     next_rdata = 32'(cur.channel_pll_powerdown);
      `TCB_OFF_TX_PLL_SEL:    next_rdata = 32'(tx_pll_source_select);
      `TCB_OFF_RX_PLL_SEL:    next_rdata = 32'(rx_pll_source_select);
      `TCB_OFF_TX_POSTCURSOR: next_rdata = 32'(cur.tx_postcursor);
      `TCB_OFF_TX_PRECURSOR:  next_rdata = 32'(cur.tx_precursor);
      `TCB_OFF_LOOPBACK:      next_rdata = 32'(cur.loopback_select);
      `TCB_OFF_TX_SYS_RESET:  next_rdata = 32'(tx_system_reset);
      `TCB_OFF_RX_SYS_RESET:  next_rdata = 32'(rx_system_reset);
      `TCB_OFF_TX_POWER:      next_rdata = 32'(cur.tx_power_state);
      `TCB_OFF_TX_SWING:      next_rdata = 32'(cur.tx_drive_swing);
      `TCB_OFF_TX_INHIBIT:    next_rdata = 32'(cur.tx_output_inhibit);
      `TCB_OFF_TX_INVERT:     next_rdata = 32'(cur.tx_invert);
      `TCB_OFF_RX_INVERT:     next_rdata = 32'(cur.rx_invert);
      `TCB_OFF_RX_EQ_SEL:     next_rdata = 32'(cur.rx_equalizer_select);
      `TCB_OFF_RX_EQ_RESET:   next_rdata = 32'(cur.rx_equalizer_reset);
      `TCB_OFF_HDR_LIMIT:     next_rdata = 32'(cur.invalid_header_limit);
      `TCB_OFF_TX_OUT_DIV:    next_rdata = 32'(cur.tx_output_divider);
      `TCB_OFF_RX_OUT_DIV:    next_rdata = 32'(cur.rx_output_divider);
      `TCB_OFF_CHANNEL_PLL_FB_CODE:  next_rdata = 32'(channel_pll_fb_code);
      `TCB_OFF_CHANNEL_PLL_REF_CODE: next_rdata = 32'(channel_pll_ref_code);
      // Decoded feedback value in [15:8], reference value in [2:0]
      `TCB_OFF_CHANNEL_PLL_DECODED:  next_rdata = {16'h0000,
                                            channel_pll_fb_code + `TCB_FB_OFFSET,
                                            5'h00, ref_value(channel_pll_ref_code)};
      `TCB_OFF_TX_LINE_RATE:  next_rdata = tx_line_rate;
      `TCB_OFF_LOCK_STATUS:   next_rdata = 32'(rx_block_lock);
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // Answer: data registered, ack decoded from the done state, one cycle in done
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= '0;
      reg_err   <= 1'b0;
    end else if (state == TCB_SYNC) begin
      reg_rdata <= req_write ? 32'h0000_0000 : next_rdata;
      reg_err   <= ~mapped;
    end
  end

  assign reg_ack = (state == TCB_DONE);

endmodule : tcb_bank

// ==== dv/tcb_sva.sv ====
// Purpose: Port checker for tcb_bank
// Assumes: Channel zero stands for every channel
// Notes:   Bound in the bench top file
`timescale 1ns/1ns
module tcb_sva import tcb_pkg::*; #(parameter int NUM_CH = 4) (
  input wire logic sys_clk, resetn, reg_ack, common_pll_zero_reset, common_pll_one_reset,
  input wire tcb_chan_type [NUM_CH-1:0] chan_ctrl,
  input wire logic [NUM_CH-1:0] tx_datapath_reset, rx_datapath_reset, channel_pll_reset,
  input wire logic [NUM_CH-1:0] tx_serial_bit, serial_out_pos, serial_out_neg, rx_serial_bit,
  input wire logic [NUM_CH-1:0] rx_serial_data, rx_header_valid, rx_header_invalid,
  input wire logic [NUM_CH-1:0] rx_block_lock,
  input wire logic [1:0] tx_pll_source_select, rx_pll_source_select
);
  // ==========================================================
  // One clock domain, so one default clocking and disable
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  a_ack_pulse: assert property (reg_ack |=> !reg_ack) else $error("ack too long");
  a_inhibit_line: assert property (chan_ctrl[0].tx_output_inhibit |=>
    !serial_out_pos[0] && serial_out_neg[0]) else $error("inhibit not idling line");
  a_tx_sense: assert property (resetn && !chan_ctrl[0].tx_output_inhibit |=>
    serial_out_pos[0] == $past(tx_serial_bit[0] ^ chan_ctrl[0].tx_invert)
    && serial_out_neg[0] != serial_out_pos[0]) else $error("tx sense wrong");
  a_rx_sense: assert property (resetn |=>
    rx_serial_data[0] == $past(rx_serial_bit[0] ^ chan_ctrl[0].rx_invert))
    else $error("rx sense wrong");
  a_pll_zero_rst: assert property (common_pll_zero_reset ==
    (tx_datapath_reset[0] && tx_pll_source_select == 2'h3
    || rx_datapath_reset[0] && rx_pll_source_select == 2'h3)) else $error("pll zero reset");
  a_pll_one_rst: assert property (common_pll_one_reset ==
    (tx_datapath_reset[0] && tx_pll_source_select == 2'h2
    || rx_datapath_reset[0] && rx_pll_source_select == 2'h2)) else $error("pll one reset");
  a_chan_pll_rst: assert property (channel_pll_reset[0] ==
    (tx_datapath_reset[0] && tx_pll_source_select == 2'h0
    || rx_datapath_reset[0] && rx_pll_source_select == 2'h0)) else $error("chan pll reset");
  a_limit_one: assert property (chan_ctrl[0].invalid_header_limit == 4'h1
    && rx_header_invalid[0] && !rx_header_valid[0] |=> !rx_block_lock[0])
    else $error("lock kept at limit one");
  a_valid_locks: assert property (resetn && rx_header_valid[0] && !rx_header_invalid[0]
    && !rx_datapath_reset[0] && !chan_ctrl[0].rx_equalizer_reset
    |=> rx_block_lock[0]) else $error("valid header did not lock");
  // Main scenarios reached
  c_inhibit: cover property (chan_ctrl[0].tx_output_inhibit);
  c_zero_rst: cover property (common_pll_zero_reset);
  c_lock_drop: cover property (rx_block_lock[0] ##1 !rx_block_lock[0]);
endmodule : tcb_sva

// ==== dv/tcb_far_end.sv ====
// Purpose: Far-end channels feeding line bits and header strobes
// Assumes: Launched just after the rising edge
// Notes:   Valid headers are rare so invalid runs reach the limit
`timescale 1ns/1ns
module tcb_far_end #(parameter int NUM_CH = 4) (
  input  wire logic              sys_clk,
  output logic      [NUM_CH-1:0] tx_serial_bit = '0,
  output logic      [NUM_CH-1:0] rx_serial_bit = '0,
  output logic      [NUM_CH-1:0] rx_header_valid = '0,
  output logic      [NUM_CH-1:0] rx_header_invalid = '0
);
  // Fresh bits every cycle so a stuck output shows at once
  always @(posedge sys_clk) begin
    tx_serial_bit <= NUM_CH'($urandom);
    rx_serial_bit <= NUM_CH'($urandom);
    rx_header_valid <= NUM_CH'($urandom & $urandom & $urandom);
    rx_header_invalid <= NUM_CH'($urandom);
  end
endmodule : tcb_far_end

// ==== dv/tcb_bank_bench.sv ====
// Purpose: Self-checking bench for tcb_bank
// Assumes: Four channels, one settle cycle
// Notes:   A monitor scores each answer against a queue of notes
`timescale 1ns/1ns
module tcb_bank_bench import tcb_pkg::*; ;
  logic sys_clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, reg_ack, reg_err;
  logic common_pll_zero_reset, common_pll_one_reset;
  logic [11:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0, pll_rate_khz = '0, reg_rdata, v, s;
  logic [1:0] tx_pll_source_select, rx_pll_source_select;
  logic [3:0] tx_datapath_reset, rx_datapath_reset, channel_pll_reset, serial_out_pos;
  logic [3:0] serial_out_neg, rx_serial_data, rx_block_lock, tx_serial_bit, rx_serial_bit;
  logic [3:0] rx_header_valid, rx_header_invalid;
  tcb_chan_type [3:0] chan_ctrl;
  logic [33:0] notes[$]; // {compare data, err, data}
  int bad_count = 0, checks_done = 0, wid[16] = '{1,2,2,5,5,3,1,1,2,4,1,1,1,1,1,4};
  always #4 sys_clk = ~sys_clk;
  tcb_bank #(.NUM_CH(4), .SYNC_CYCLES(1)) tcb_bank_inst (.sys_clk, .resetn, .reg_addr,
    .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_ack, .reg_err, .chan_ctrl,
    .tx_datapath_reset, .rx_datapath_reset, .channel_pll_reset, .common_pll_zero_reset,
    .common_pll_one_reset, .tx_pll_source_select, .rx_pll_source_select, .tx_serial_bit,
    .serial_out_pos, .serial_out_neg, .rx_serial_bit, .rx_serial_data, .rx_header_valid,
    .rx_header_invalid, .rx_block_lock, .pll_rate_khz);
  tcb_far_end #(.NUM_CH(4)) tcb_far_end_inst (.sys_clk, .tx_serial_bit, .rx_serial_bit,
    .rx_header_valid, .rx_header_invalid);
  // ==========================================================
  // Scoring and bus tasks
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Holds the strobe until ack is seen at an edge, drops it at that edge
  task automatic access(logic [11:0] a, logic w, logic [31:0] d, logic [33:0] exp);
    int n = 0;
    notes.push_back(exp);
    @(posedge sys_clk);
    {reg_addr, reg_wr, reg_rd, reg_wdata} <= {a, w, !w, d};
    do begin
      @(posedge sys_clk);
      n++;
    end while (reg_ack !== 1'b1 && n < 20);
    {reg_wr, reg_rd} <= 2'b00;
    if (n >= 20) bad_count++;
  endtask : access
  task automatic wr(logic [11:0] a, logic [31:0] d);
    access(a, 1'b1, d, '0);
  endtask : wr
  task automatic rd(logic [11:0] a, logic [31:0] d);
    access(a, 1'b0, '0, {2'b10, d});
  endtask : rd
  // Monitor takes the oldest note at every ack
  always @(posedge sys_clk) begin
    if (reg_ack === 1'b1 && notes.size() > 0) begin
      logic [33:0] nt;
      nt = notes.pop_front();
      check("err", {31'h0, reg_err}, {31'h0, nt[32]});
      if (nt[33]) check("rdata", reg_rdata, nt[31:0]);
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize
  // ==========================================================
  // Scenarios
  initial begin
    v = $urandom(7651);
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    for (int i = 0; i < 16; i++) // Reset values, swing C, equalizer 1, limit 8
      rd(12'h300 + 12'(4*i), i == 9 ? 32'hC : i == 13 ? 32'h1 : i == 15 ? 32'h8 : 0);
    wr(12'h024, 32'h1);
    for (int i = 0; i < 16; i++) begin // Random round trip on channel one
      v = $urandom & ((32'h1 << wid[i]) - 1);
      if (i inside {1, 2, 5}) v &= 32'h2;
      if (i == 15) v = v % 8 + 1;
      wr(12'h300 + 12'(4*i), v);
      rd(12'h300 + 12'(4*i), v);
    end
    for (int i = 0; i < 8; i++) begin // Loopback codes 0, 1, 2, 4 and 6 and every source code, index moved
      v = 32'(i > 2 ? i & 6 : i);
      s = i < 3 ? {|v[1:0], v[1]} : 32'h3;
      wr(12'h024, 32'(i & 3));
      wr(12'h314, v);
      check("loopback", 32'(chan_ctrl[i & 3].loopback_select), v);
      if (i < 3) wr(12'h304, s);
      if (i < 3) wr(12'h308, s);
      rd(12'h304, s);
      check("rx source", 32'(rx_pll_source_select), s);
    end
    wr(12'h318, 32'h1);
    check("tx resets", {tx_datapath_reset, 3'h0, common_pll_zero_reset}, 32'hF1);
    wr(12'h304, 32'h0);
    check("chan pll", 32'(channel_pll_reset), 32'hF);
    wr(12'h31C, 32'h1);
    wr(12'h318, 32'h0);
    check("rx resets", {rx_datapath_reset, 3'h0, common_pll_zero_reset}, 32'hF1);
    wr(12'h308, 32'h2);
    check("pll one", 32'(common_pll_one_reset), 32'h1);
    wr(12'h31C, 32'h0);
    wr(12'h024, 32'h2);
    wr(12'h30C, 32'h15);
    check("post", {chan_ctrl[2].tx_postcursor, chan_ctrl[0].tx_postcursor}, 32'h2A0);
    wr(12'h024, 32'h7);
    rd(12'h024, 32'h2);
    access(12'h3FC, 1'b0, '0, {2'b01, 32'h0});
    wr(12'h024, 32'h0);
    wr(12'h33C, 32'h1);
    for (int i = 0; i < 3; i++) begin // Inhibit, then invert both ways, with short limit
      wr(12'h328 + 12'(4*i), 32'h1);
      repeat (20) @(posedge sys_clk);
    end
    wr(12'h328, 32'h0);
    repeat (40) @(posedge sys_clk);
    wr(12'h334, 32'h0);
    wr(12'h338, 32'h1);
    wr(12'h338, 32'h0);
    pll_rate_khz <= $urandom >> 2;
    wr(12'h340, 32'h3);
    rd(12'h354, (pll_rate_khz * 2) >> 3);
    wr(12'h348, 32'd62);
    wr(12'h34C, 32'h10);
    rd(12'h350, 32'h4001);
    summarize();
  end
  initial begin
    #200000;
    bad_count++;
    summarize();
  end
endmodule : tcb_bank_bench
bind tcb_bank tcb_sva #(.NUM_CH(NUM_CH)) tcb_sva_inst (.sys_clk, .resetn, .reg_ack,
  .common_pll_zero_reset, .common_pll_one_reset, .chan_ctrl, .tx_datapath_reset,
  .rx_datapath_reset, .channel_pll_reset, .tx_serial_bit, .serial_out_pos, .serial_out_neg,
  .rx_serial_bit, .rx_serial_data, .rx_header_valid, .rx_header_invalid, .rx_block_lock,
  .tx_pll_source_select, .rx_pll_source_select);
